//--- rtl/acc_adc_config.sv
/*
 * APB register file and conversion sequencer of the ADC configuration block.
 * Assumes a 32-bit APB master and an analog core that pulses coreDone with
 * coreData valid once per started conversion.
 */
// The APB register port is this design's own decision.
// What this block does
// - Four-bit code picks conversion reference source.
// - Adjust field divides sum by power two.
// - Sample count code sums two-power samples.
// - Sampling lasts field plus one half periods.
// - Prescaler divides clock by four to 512.
// - Prescaler writable only while converter disabled.
// - Resolution field selects 12/16/10/8 bit format.
// - Resolution writable only while converter disabled.
// - Correction enable applies gain and offset.
// - Correction adds cycles set by offset.
// - Free running restarts; otherwise one per trigger.
// - Left align moves result to upper bits.
// - Differential mode converts positive minus negative.
// - Mode bits change only while converter disabled.
// - Reserved bits read zero, written zero.
// - Enable change synchronised, pending flag meanwhile.
`timescale 1ns/100ps
module acc_adc_config
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic coreDone,
	input wire logic [11:0] coreData,
	output logic [3:0] referenceSelect,
	output logic adcClk,
	output logic coreSample,
	output logic coreStart,
	output logic coreDifferential
);
	// Bus decode
	logic [3:0] idx; // Word index
	logic mapped; // Address hits a register
	logic busDone; // Access completes this edge
	logic wrDone; // Write completes this edge
	logic locked; // Protected fields frozen

	// Configuration storage
	logic enable_reg; // Enable as written, reads back at once
	logic enableActive_reg; // Enable after synchronisation
	logic [2:0] syncCount_reg; // Remaining synchronisation cycles
	logic syncPending_reg; // Enable change in flight
	logic [3:0] reference_select_reg; // Reference code
	logic [3:0] sampleCount_reg; // Sample count code
	logic [2:0] adjust_reg; // Result adjust shift
	logic [5:0] samplingLen_reg; // Sampling length
	logic [2:0] prescaler_reg; // Prescaler code
	logic [1:0] resolution_reg; // Resolution code
	logic correction_reg; // Gain and offset correction on
	logic continuous_conversion_reg; // Continuous conversion
	logic leftAlign_reg; // Left-aligned result
	logic differential_reg; // Differential input
	logic [11:0] gain_reg; // Gain calibration
	logic [11:0] offset_reg; // Offset calibration, signed
	logic [15:0] result_reg; // Last result
	logic startPending_reg; // Trigger waiting for the sequencer

	// Sequencer state
	acc_state_t state_reg;
	logic [6:0] halfCount_reg; // Half periods sampled
	logic [10:0] sample_count_select_reg; // Samples summed so far
	logic [21:0] sum_reg; // Accumulated sum
	logic [11:0] sample_reg; // Sample after correction and scaling
	logic [3:0] extra_reg; // Extra correction cycles left
	logic halfTick; // Half period of the ADC clock

	// Datapath helpers
	logic [12:0] corrDiff; // Raw minus offset
	logic [25:0] corrProd; // Difference times gain
	logic [25:0] corrShift; // Product scaled back
	logic [11:0] corrected; // Clamped corrected sample
	logic [11:0] scaled; // Sample at selected resolution
	logic [10:0] sampleTarget; // Samples per result
	logic [21:0] sum_next; // Sum including current sample
	logic [21:0] avgShift; // Sum after adjust shift
	logic [15:0] formatted; // Result after alignment

	assign idx = paddr[IDX_MSB:IDX_LSB];
	assign mapped = (paddr[ADDR_W-1:IDX_MSB+1] == '0) && (idx <= IDX_LAST);
	assign busDone = psel && penable && pready;
	assign wrDone = busDone && pwrite && mapped;
	assign locked = enable_reg || enableActive_reg;

	acc_clock_divider divider (
		.clk(clk),
		.rst(rst),
		.run(enableActive_reg),
		.prescale(prescaler_reg),
		.halfTick(halfTick)
	);

	// APB answer one cycle into the access phase, read data with it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (psel && penable && !pready) begin
			pready <= 1'b1;
			pslverr <= !mapped;
			prdata <= 32'h0000_0000; // Reserved bits read zero
			if (!pwrite && mapped) begin
				case (idx)
					IDX_PRIMARY: prdata[PRI_ENABLE_BIT] <= enable_reg;
					IDX_REFERENCE: prdata[REF_SEL_LSB+:4] <= reference_select_reg;
					IDX_AVERAGING: begin
						prdata[AVG_COUNT_LSB+:4] <= sampleCount_reg;
						prdata[AVG_ADJ_LSB+:3] <= adjust_reg;
					end
					IDX_SAMPLING: prdata[SAMP_LEN_LSB+:6] <= samplingLen_reg;
					IDX_CONVERSION: begin
						prdata[CONV_DIFF_BIT] <= differential_reg;
						prdata[CONV_LEFT_BIT] <= leftAlign_reg;
						prdata[CONV_FREE_BIT] <= continuous_conversion_reg;
						prdata[CONV_CORR_BIT] <= correction_reg;
						prdata[CONV_RES_LSB+:2] <= resolution_reg;
						prdata[CONV_PRESC_LSB+:3] <= prescaler_reg;
					end
					IDX_STATUS: begin
						prdata[STAT_SYNC_BIT] <= syncPending_reg;
						prdata[STAT_BUSY_BIT] <= (state_reg != ST_IDLE);
					end
					IDX_CALIB: begin
						prdata[CAL_OFFSET_LSB+:12] <= offset_reg;
						prdata[CAL_GAIN_LSB+:12] <= gain_reg;
					end
					IDX_RESULT: prdata[15:0] <= result_reg;
					default: prdata <= 32'h0000_0000; // Trigger reads zero
				endcase
			end
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end

	// Enable write reads back at once, takes effect after a delay
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enable_reg <= 1'b0;
			enableActive_reg <= 1'b0;
			syncCount_reg <= 3'h0;
			syncPending_reg <= 1'b0;
		end else if (wrDone && idx == IDX_PRIMARY) begin
			enable_reg <= pwdata[PRI_ENABLE_BIT];
			syncCount_reg <= SYNC_CYCLES;
			syncPending_reg <= 1'b1;
		end else if (syncCount_reg != 3'h0) begin
			syncCount_reg <= syncCount_reg - 3'h1;
			if (syncCount_reg == 3'h1) begin
				enableActive_reg <= enable_reg;
				syncPending_reg <= 1'b0;
			end
		end
	end

	// Unprotected fields: reference, averaging, sampling, calibration
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reference_select_reg <= REF_SEL_RESET;
			sampleCount_reg <= AVG_RESET[AVG_COUNT_LSB+:4];
			adjust_reg <= AVG_RESET[AVG_ADJ_LSB+:3];
			samplingLen_reg <= SAMP_LEN_RESET;
			gain_reg <= GAIN_RESET;
			offset_reg <= OFFSET_RESET;
		end else if (wrDone) begin
			case (idx)
				IDX_REFERENCE: reference_select_reg <= pwdata[REF_SEL_LSB+:4];
				IDX_AVERAGING: begin
					sampleCount_reg <= pwdata[AVG_COUNT_LSB+:4];
					adjust_reg <= pwdata[AVG_ADJ_LSB+:3];
				end
				IDX_SAMPLING: samplingLen_reg <= pwdata[SAMP_LEN_LSB+:6];
				IDX_CALIB: begin
					offset_reg <= pwdata[CAL_OFFSET_LSB+:12];
					gain_reg <= pwdata[CAL_GAIN_LSB+:12];
				end
				default: ;
			endcase
		end
	end

	// Enable-protected fields keep their value while enabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			prescaler_reg <= PRESC_RESET;
			resolution_reg <= RES_RESET;
			correction_reg <= 1'b0;
			continuous_conversion_reg <= 1'b0;
			leftAlign_reg <= 1'b0;
			differential_reg <= 1'b0;
		end else if (wrDone && idx == IDX_CONVERSION && !locked) begin
			prescaler_reg <= pwdata[CONV_PRESC_LSB+:3];
			resolution_reg <= pwdata[CONV_RES_LSB+:2];
			correction_reg <= pwdata[CONV_CORR_BIT];
			continuous_conversion_reg <= pwdata[CONV_FREE_BIT];
			leftAlign_reg <= pwdata[CONV_LEFT_BIT];
			differential_reg <= pwdata[CONV_DIFF_BIT];
		end
	end

	// Trigger flag; a new trigger wins over the sequencer's clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			startPending_reg <= 1'b0;
		end else if (wrDone && idx == IDX_TRIGGER && pwdata[TRIG_START_BIT]) begin
			startPending_reg <= 1'b1;
		end else if (state_reg == ST_IDLE && enableActive_reg) begin
			startPending_reg <= 1'b0;
		end
	end

	// Gain and offset correction, then scaling to the resolution
	always_comb begin
		corrDiff = {1'b0, coreData} - {offset_reg[11], offset_reg};
		corrProd = 26'($signed(corrDiff) * $signed({1'b0, gain_reg}));
		corrShift = 26'($signed(corrProd) >>> CORR_SHIFT);
		if (corrShift[25]) begin
			corrected = 12'h000; // Clamp below zero
		end else if (corrShift[24:12] != 13'h0000) begin
			corrected = 12'hfff; // Clamp above full scale
		end else begin
			corrected = corrShift[11:0];
		end
		case (resolution_reg)
			RES_10BIT: scaled = (correction_reg ? corrected : coreData) >> 2;
			RES_8BIT: scaled = (correction_reg ? corrected : coreData) >> 4;
			default: scaled = correction_reg ? corrected : coreData;
		endcase
	end

	// Averaging target, shifted sum and alignment
	always_comb begin
		if (sampleCount_reg > SAMPLE_COUNT_MAX) begin
			sampleTarget = 11'h001 << SAMPLE_COUNT_MAX; // Reserved codes act as 1024
		end else begin
			sampleTarget = 11'h001 << sampleCount_reg;
		end
		sum_next = sum_reg + {10'h000, sample_reg};
		avgShift = sum_next >> adjust_reg;
		formatted = avgShift[15:0];
		if (leftAlign_reg) begin
			case (resolution_reg)
				RES_12BIT: formatted = {avgShift[11:0], 4'h0};
				RES_10BIT: formatted = {avgShift[9:0], 6'h00};
				RES_8BIT: formatted = {avgShift[7:0], 8'h00};
				default: formatted = avgShift[15:0];
			endcase
		end
	end

	// Conversion sequencer: sample, convert, correct, accumulate
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			halfCount_reg <= 7'h00;
			sample_count_select_reg <= 11'h000;
			sum_reg <= 22'h000000;
			sample_reg <= 12'h000;
			extra_reg <= 4'h0;
			result_reg <= 16'h0000;
			coreSample <= 1'b0;
			coreStart <= 1'b0;
		end else if (!enableActive_reg) begin
			state_reg <= ST_IDLE; // Disabling aborts any conversion
			sample_count_select_reg <= 11'h000;
			sum_reg <= 22'h000000;
			coreSample <= 1'b0;
			coreStart <= 1'b0;
		end else begin
			coreStart <= 1'b0;
			case (state_reg)
				ST_IDLE: begin
					if (startPending_reg) begin
						state_reg <= ST_SAMPLE;
						halfCount_reg <= 7'h00;
						coreSample <= 1'b1;
					end
				end
				ST_SAMPLE: begin
					if (halfTick) begin
						if (halfCount_reg == {1'b0, samplingLen_reg}) begin
							coreSample <= 1'b0;
							coreStart <= 1'b1;
							state_reg <= ST_CONVERT;
						end else begin
							halfCount_reg <= halfCount_reg + 7'h01;
						end
					end
				end
				ST_CONVERT: begin
					if (coreDone) begin
						sample_reg <= scaled;
						extra_reg <= offset_reg[3:0];
						state_reg <= correction_reg ? ST_CORRECT : ST_ACCUM;
					end
				end
				ST_CORRECT: begin
					if (extra_reg == 4'h0) begin
						state_reg <= ST_ACCUM;
					end else begin
						extra_reg <= extra_reg - 4'h1;
					end
				end
				ST_ACCUM: begin
					halfCount_reg <= 7'h00;
					if (sample_count_select_reg + 11'h001 == sampleTarget) begin
						result_reg <= formatted;
						sum_reg <= 22'h000000;
						sample_count_select_reg <= 11'h000;
						state_reg <= continuous_conversion_reg ? ST_SAMPLE : ST_IDLE;
						coreSample <= continuous_conversion_reg;
					end else begin
						sum_reg <= sum_next;
						sample_count_select_reg <= sample_count_select_reg + 11'h001;
						state_reg <= ST_SAMPLE;
						coreSample <= 1'b1;
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// Analog-side configuration and the ADC clock
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			referenceSelect <= REF_SEL_RESET;
			coreDifferential <= 1'b0;
			adcClk <= 1'b0;
		end else begin
			referenceSelect <= reference_select_reg;
			coreDifferential <= differential_reg;
			if (!enableActive_reg) begin
				adcClk <= 1'b0;
			end else if (halfTick) begin
				adcClk <= !adcClk;
			end
		end
	end
endmodule

//--- rtl/acc_pkg.sv
/*
 * Shared constants and types of the ADC conversion configuration block:
 * register indices, field positions, reset values, codes and timing counts.
 * Assumes a 32-bit APB slave where each register takes one aligned word
 * at byte address four times its index.
 */
package acc_pkg;
	// Register indices (byte address is four times the index)
	localparam logic [3:0] IDX_PRIMARY = 4'h0; // Enable bit
	localparam logic [3:0] IDX_REFERENCE = 4'h1; // Reference select
	localparam logic [3:0] IDX_AVERAGING = 4'h2; // Sample count and adjust shift
	localparam logic [3:0] IDX_SAMPLING = 4'h3; // Sampling length
	localparam logic [3:0] IDX_CONVERSION = 4'h4; // Protected conversion bits
	localparam logic [3:0] IDX_STATUS = 4'h5; // Sync pending and busy
	localparam logic [3:0] IDX_CALIB = 4'h6; // Gain and offset calibration
	localparam logic [3:0] IDX_RESULT = 4'h7; // Conversion result
	localparam logic [3:0] IDX_TRIGGER = 4'h8; // Start conversion
	localparam logic [3:0] IDX_LAST = 4'h8; // Highest mapped index
	localparam int ADDR_W = 12; // APB address width
	localparam int IDX_LSB = 2; // Word index position in the address
	localparam int IDX_MSB = 5;

	// Field positions
	localparam int PRI_ENABLE_BIT = 1;
	localparam int REF_SEL_LSB = 0;
	localparam int AVG_COUNT_LSB = 0;
	localparam int AVG_ADJ_LSB = 4;
	localparam int SAMP_LEN_LSB = 0;
	localparam int CONV_DIFF_BIT = 0;
	localparam int CONV_LEFT_BIT = 1;
	localparam int CONV_FREE_BIT = 2;
	localparam int CONV_CORR_BIT = 3;
	localparam int CONV_RES_LSB = 4;
	localparam int CONV_PRESC_LSB = 8;
	localparam int STAT_SYNC_BIT = 0;
	localparam int STAT_BUSY_BIT = 1;
	localparam int CAL_OFFSET_LSB = 0;
	localparam int CAL_GAIN_LSB = 16;
	localparam int TRIG_START_BIT = 0;

	// Reset values
	localparam logic [3:0] REF_SEL_RESET = 4'h0;
	localparam logic [7:0] AVG_RESET = 8'h00;
	localparam logic [5:0] SAMP_LEN_RESET = 6'h00;
	localparam logic [2:0] PRESC_RESET = 3'h0;
	localparam logic [1:0] RES_RESET = 2'h0;
	localparam logic [11:0] GAIN_RESET = 12'h800; // Unity gain
	localparam logic [11:0] OFFSET_RESET = 12'h000;

	// Reference select codes
	localparam logic [3:0] REF_INTERNAL_ONE_VOLT = 4'h0;
	localparam logic [3:0] REF_SUPPLY_FRACTION_A = 4'h1;
	localparam logic [3:0] REF_SUPPLY_HALF = 4'h2;
	localparam logic [3:0] REF_EXTERNAL_A = 4'h3;
	localparam logic [3:0] REF_EXTERNAL_B = 4'h4;

	// Resolution codes
	localparam logic [1:0] RES_12BIT = 2'h0;
	localparam logic [1:0] RES_16BIT = 2'h1;
	localparam logic [1:0] RES_10BIT = 2'h2;
	localparam logic [1:0] RES_8BIT = 2'h3;

	// Averaging and correction
	localparam logic [3:0] SAMPLE_COUNT_MAX = 4'ha; // 1024 samples
	localparam int CORR_SHIFT = 11; // Gain of 0x800 is unity

	// Cycles from an enable write until the change takes effect
	localparam logic [2:0] SYNC_CYCLES = 3'h4;

	// Conversion sequencer states
	typedef enum logic [2:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_CORRECT, ST_ACCUM} acc_state_t;
endpackage

//--- rtl/acc_clock_divider.sv
/*
 * Prescaler producing half-period ticks of the ADC conversion clock.
 * Assumes run is held high while the converter is enabled.
 */
`timescale 1ns/100ps
module acc_clock_divider
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic run,
	input wire logic [2:0] prescale,
	output logic halfTick
);
	logic [8:0] countReg; // Peripheral clocks within a half period
	logic [8:0] halfLast; // Last count of a half period

	// Divisor is 4 << code, so a half period is 2 << code clocks
	assign halfLast = (9'h002 << prescale) - 9'h001;

	// Free count while running, restarts from zero when stopped
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			countReg <= 9'h000;
			halfTick <= 1'b0;
		end else if (!run) begin
			countReg <= 9'h000;
			halfTick <= 1'b0;
		end else if (countReg == halfLast) begin
			countReg <= 9'h000;
			halfTick <= 1'b1;
		end else begin
			countReg <= countReg + 9'h001;
			halfTick <= 1'b0;
		end
	end
endmodule

//--- testbench/acc_adc_config_chk.sv
/*
 * Port checker of the ADC configuration block, attached by bind.
 * Assumes one clock domain and the one-wait-state APB answer.
 */
`timescale 1ns/100ps
module acc_adc_config_chk
	import acc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [3:0] referenceSelect,
	input wire logic adcClk,
	input wire logic coreSample,
	input wire logic coreStart,
	input wire logic coreDifferential
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	wire logic wrDone = psel && penable && pready && pwrite; // Write lands here
	wire logic [3:0] idx = paddr[IDX_MSB:IDX_LSB]; // Word index
	logic enWritten; // Last written enable
	logic [3:0] refShadow; // Last written reference code
	logic [3:0] offCnt; // Cycles spent disabled, saturating
	wire logic convOpen = wrDone && idx == IDX_CONVERSION && !enWritten; // Unlocked write
	// Shadow the written enable and reference code
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			enWritten <= 1'b0;
			refShadow <= 4'h0;
		end else begin
			if (wrDone && idx == IDX_PRIMARY) enWritten <= pwdata[PRI_ENABLE_BIT];
			if (wrDone && idx == IDX_REFERENCE) refShadow <= pwdata[3:0];
		end
	end
	// Count how long the converter has been disabled
	always_ff @(posedge clk or posedge rst) begin
		if (rst) offCnt <= 4'h0;
		else if (enWritten) offCnt <= 4'h0;
		else if (offCnt != 4'hf) offCnt <= offCnt + 4'h1;
	end
	sequence s_refWrite; wrDone && idx == IDX_REFERENCE; endsequence
	sequence s_sampleEnd; $fell(coreSample) && coreStart; endsequence
	property p_readyOnce; pready |=> !pready; endproperty
	a_readyOnce: assert property (p_readyOnce) else $error("pready longer than one cycle");
	property p_readyWait; psel && penable && !pready |=> pready; endproperty
	a_readyWait: assert property (p_readyWait) else $error("pready late");
	property p_unmapped; pready && idx > IDX_LAST |-> pslverr && prdata == 32'h0; endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	property p_refFollows; s_refWrite |-> ##[1:2] referenceSelect == refShadow; endproperty
	a_refFollows: assert property (p_refFollows) else $error("reference not applied");
	property p_diffLocked; $changed(coreDifferential) |-> $past(convOpen) || $past(convOpen, 2);
	endproperty
	a_diffLocked: assert property (p_diffLocked) else $error("mode bit changed");
	property p_startAfterSample; $rose(coreStart) |-> s_sampleEnd; endproperty
	a_startAfterSample: assert property (p_startAfterSample) else $error("start early");
	property p_startPulse; coreStart |=> !coreStart; endproperty
	a_startPulse: assert property (p_startPulse) else $error("start pulse too long");
	property p_idleOff; offCnt >= 4'ha |-> !adcClk && !coreSample && !coreStart; endproperty
	a_idleOff: assert property (p_idleOff) else $error("active while disabled");
endmodule

bind acc_adc_config acc_adc_config_chk CHK (.clk, .rst, .psel, .penable, .pwrite, .paddr,
	.pwdata, .prdata, .pready, .pslverr, .referenceSelect, .adcClk, .coreSample, .coreStart,
	.coreDifferential);

//--- testbench/acc_core_model.sv
/*
 * Stand-in for the analog converter core.
 * Assumes one start pulse per conversion; answers after a set latency.
 */
`timescale 1ns/100ps
module acc_core_model
(
	input wire logic clk,
	input wire logic rst,
	input wire logic coreStart,
	input wire logic [7:0] latency,
	input wire logic [11:0] sampleValue,
	output logic coreDone,
	output logic [11:0] coreData
);
	logic busy; // Conversion in flight
	logic [7:0] waitCnt; // Cycles left before answering
	// Answer after the latency; data scrambles outside the done cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			busy <= 1'b0;
			waitCnt <= 8'h00;
			coreDone <= 1'b0;
			coreData <= 12'h000;
		end else begin
			coreDone <= 1'b0;
			coreData <= ~coreData;
			if (coreStart) begin
				busy <= 1'b1;
				waitCnt <= latency;
			end else if (busy && waitCnt == 8'h00) begin
				busy <= 1'b0;
				coreDone <= 1'b1;
				coreData <= sampleValue;
			end else if (busy) waitCnt <= waitCnt - 8'h01;
		end
	end
endmodule

//--- testbench/tb_acc_adc_config.sv
/*
 * Self-checking bench of the ADC configuration block over APB.
 * Assumes the core stand-in model and the bound port checker.
 */
`timescale 1ns/100ps
module tb_acc_adc_config
	import acc_pkg::*;
;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [ADDR_W-1:0] paddr = '0;
	logic [31:0] pwdata = '0;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, err, coreDone, coreSample, coreStart, coreDifferential, adcClk;
	logic [11:0] coreData;
	logic [3:0] referenceSelect;
	logic [7:0] latency = 8'h00; // Core answer delay
	int errors = 0;
	int nTests = 0;
	int starts = 0; // Start pulses seen
	int n0, len, h;
	// Register addresses, reset values and writable masks
	logic [11:0] ra [5] = '{12'h004, 12'h008, 12'h00c, 12'h010, 12'h018};
	logic [31:0] rv [5] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0800_0000};
	logic [31:0] rm [5] = '{32'hf, 32'h7f, 32'h3f, 32'h73f, 32'h0fff_0fff};
	// Conversion cases: control, averaging, expected result, samples
	logic [31:0] cv [6] = '{32'h000, 32'h002, 32'h110, 32'h031, 32'h020, 32'h008};
	logic [31:0] av [6] = '{32'h0, 32'h0, 32'h12, 32'h0, 32'h0, 32'h0};
	logic [31:0] ex [6] = '{32'habc, 32'habc0, 32'h1578, 32'hab, 32'h2af, 32'haac};
	int ns [6] = '{1, 1, 4, 1, 1, 1};

	always #25 clk = ~clk;
	// Count conversion starts
	always @(posedge clk) if (coreStart === 1'b1) starts <= starts + 1;

	acc_adc_config DUT (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .coreDone, .coreData, .referenceSelect, .adcClk, .coreSample, .coreStart,
		.coreDifferential);
	acc_core_model MODEL (.clk, .rst, .coreStart, .latency, .sampleValue(12'habc), .coreDone,
		.coreData);

	// Compare and count
	task check(input logic [31:0] seen, input logic [31:0] exp);
		nTests++;
		if (seen !== exp) begin
			errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One APB transfer; holds the request until pready is sampled
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		check(32'(pready), 32'h1);
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Reconfigure while disabled, re-enable, then time one adcClk high phase
	task cfg(input logic [31:0] c, input logic [31:0] a);
		int i;
		xfer(1'b1, 12'h000, 32'h0);
		repeat (8) @(posedge clk);
		xfer(1'b1, 12'h010, c);
		xfer(1'b1, 12'h008, a);
		xfer(1'b1, 12'h000, 32'h2);
		repeat (8) @(posedge clk);
		check(32'(coreDifferential), 32'(c[0]));
		h = 2 << c[10:8];
		i = 0;
		while (adcClk !== 1'b0 && i < 99) begin @(posedge clk); i++; end
		while (adcClk !== 1'b1 && i < 99) begin @(posedge clk); i++; end
		len = 0;
		while (adcClk === 1'b1 && len < 99) begin @(posedge clk); len++; end
		check(32'(len), 32'(h));
	endtask

	// Trigger, time the sampling window, wait idle, check the result
	task conv(input logic [31:0] e, input int n);
		int i;
		n0 = starts;
		xfer(1'b1, 12'h020, 32'h1);
		i = 0;
		while (coreSample !== 1'b1 && i < 50) begin @(posedge clk); i++; end
		len = 0;
		while (coreSample === 1'b1 && len < 600) begin @(posedge clk); len++; end
		check(32'(len >= 2 * h && len <= 3 * h + 2), 32'h1);
		i = 0;
		do begin
			xfer(1'b0, 12'h014, 32'h0);
			i++;
		end while (rdata[1] !== 1'b0 && i < 200);
		xfer(1'b0, 12'h01c, 32'h0);
		check(rdata, e);
		check(32'(starts - n0), 32'(n));
	endtask

	// Verdict and end of run
	task print_verdict;
		if (errors == 0 && nTests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	// Main sequence
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int k = 0; k < 5; k++) begin
			xfer(1'b0, ra[k], 32'h0);
			check(rdata, rv[k]);
			xfer(1'b1, ra[k], 32'hffff_ffff);
			xfer(1'b0, ra[k], 32'h0);
			check(rdata, rm[k]);
		end
		xfer(1'b1, 12'h024, 32'hffff_ffff);
		check(32'(err), 32'h1);
		xfer(1'b0, 12'h024, 32'h0);
		check(rdata, 32'h0);
		for (int r = 0; r < 5; r++) begin
			xfer(1'b1, 12'h004, 32'(r));
			xfer(1'b0, 12'h004, 32'h0);
			check(rdata, 32'(r));
			check(32'(referenceSelect), 32'(r));
		end
		xfer(1'b1, 12'h018, 32'h0800_0010);
		xfer(1'b1, 12'h00c, 32'h2);
		// Protected bits hold while enabled; disabling shows sync pending
		cfg(32'h0, 32'h0);
		xfer(1'b1, 12'h010, 32'h731);
		xfer(1'b0, 12'h010, 32'h0);
		check(rdata, 32'h0);
		check(32'(coreDifferential), 32'h0);
		xfer(1'b1, 12'h000, 32'h0);
		xfer(1'b0, 12'h014, 32'h0);
		check(32'(rdata[0]), 32'h1);
		repeat (8) @(posedge clk);
		xfer(1'b0, 12'h014, 32'h0);
		check(rdata, 32'h0);
		for (int k = 0; k < 6; k++) begin
			cfg(cv[k], av[k]);
			latency <= 8'(k * 3);
			conv(ex[k], ns[k]);
		end
		// Free running restarts until disabled
		cfg(32'h004, 32'h0);
		n0 = starts;
		xfer(1'b1, 12'h020, 32'h1);
		repeat (200) @(posedge clk);
		check(32'(starts - n0 > 2), 32'h1);
		xfer(1'b1, 12'h000, 32'h0);
		repeat (10) @(posedge clk);
		n0 = starts;
		repeat (50) @(posedge clk);
		check(32'(starts - n0), 32'h0);
		print_verdict;
	end

	// Watchdog against a hang
	initial begin
		repeat (40000) @(posedge clk);
		errors++;
		print_verdict;
	end
endmodule
